// file: hdl/vf_framer.sv
// Purpose: Frame position tracking, framing error flags and marker recovery
// Assumes: Inputs synchronous to clk; aclken freezes all state when low
// Notes:   Output register is a single stage, so throughput is one beat per two clocks
//
// The address map and the Avalon-MM register port are this design's own decisions.
`timescale 1ns/100ps
module vf_framer #(
   parameter int INIT_LEN = vf_pkg::INIT_CYCLES
) (
   // Clock, enable, reset
   input  wire logic                     clk,
   input  wire logic                     aclken,
   input  wire logic                     reset_n,
   // Stream in
   input  wire logic [vf_pkg::PIX_W-1:0] s_axis_tdata,
   input  wire logic                     s_axis_tvalid,
   input  wire logic                     s_axis_tuser,
   input  wire logic                     s_axis_tlast,
   output logic                          s_axis_tready,
   // Stream out
   output logic [vf_pkg::PIX_W-1:0]      m_axis_tdata,
   output logic                          m_axis_tvalid,
   output logic                          m_axis_tuser,
   output logic                          m_axis_tlast,
   input  wire logic                     m_axis_tready,
   // Avalon-MM register slave
   input  wire logic [3:0]               avs_address,
   input  wire logic                     avs_read,
   input  wire logic                     avs_write,
   input  wire logic [31:0]              avs_writedata,
   input  wire logic [3:0]               avs_byteenable,
   output logic [31:0]                   avs_readdata,
   output logic                          avs_waitrequest
);

   localparam vf_pkg::vf_regs_t REGS_RST = '{st: vf_pkg::VF_INIT, size: vf_pkg::SIZE_RST,
                                             waitreq: 1'b1, default: '0};

   vf_pkg::vf_regs_t           r;
   vf_pkg::vf_regs_t           n;
   logic [vf_pkg::CNT_W-1:0]   cols_m1;
   logic [vf_pkg::CNT_W-1:0]   rows_m1;
   logic [vf_pkg::CNT_W-1:0]   pc;
   logic [vf_pkg::CNT_W-1:0]   pr;
   logic                       take;
   logic                       proc;
   logic                       at_sof;
   logic                       sof_early;
   logic                       bus_req;
   logic                       bus_wr;
   logic                       err_clr_hit;
   logic [31:0]                rd_mux;

   function automatic logic [31:0] be_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                           input logic [3:0] be);
      logic [31:0] res;
      res = old_v;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            res[8*i +: 8] = new_v[8*i +: 8];
         end
      end
      return res;
   endfunction

   always_comb begin
      n         = r;
      // Size halves, minus one, cut to counter width
      cols_m1   = r.size[vf_pkg::SIZE_COLS_LSB +: vf_pkg::CNT_W] - 13'h1; // [RQ17]
      rows_m1   = r.size[vf_pkg::SIZE_ROWS_LSB +: vf_pkg::CNT_W] - 13'h1; // [RQ17]
      take      = aclken && s_axis_tvalid && r.s_ready;                     // [RQ20]
      bus_req   = avs_read || avs_write;
      bus_wr    = avs_write && !r.waitreq;
      err_clr_hit = bus_wr && (avs_address == vf_pkg::ADDR_ERROR) && avs_byteenable[0];
      // Frame start seen early restarts position tracking at the origin
      at_sof    = (r.col == 13'h0) && (r.row == 13'h0);
      sof_early = s_axis_tuser && !at_sof;                                  // [RQ6]
      pc        = sof_early ? 13'h0 : r.col;
      pr        = sof_early ? 13'h0 : r.row;
      proc      = take && ((r.st == vf_pkg::VF_RUN) ||
                           (r.st != vf_pkg::VF_INIT && r.st != vf_pkg::VF_IDLE && s_axis_tuser));
      rd_mux    = 32'h0;
      unique case (avs_address)
         vf_pkg::ADDR_CTRL:   rd_mux[vf_pkg::CTRL_EN_BIT] = r.en;
         vf_pkg::ADDR_STATUS: begin
            rd_mux[vf_pkg::STAT_DONE_BIT]  = (r.st == vf_pkg::VF_IDLE);            // [RQ14]
            rd_mux[vf_pkg::STAT_BUSY_BIT]  = (r.st == vf_pkg::VF_RUN) || r.m_valid; // [RQ14]
            rd_mux[vf_pkg::STAT_FLUSH_BIT] = (r.st == vf_pkg::VF_FLUSH_LINE) ||
                                             (r.st == vf_pkg::VF_FLUSH_FRAME);
            rd_mux[vf_pkg::STAT_INIT_BIT]  = (r.st == vf_pkg::VF_INIT);
         end
         vf_pkg::ADDR_ERROR:  rd_mux[3:0] = r.err;                                  // [RQ16]
         vf_pkg::ADDR_SIZE:   rd_mux = r.size;
         default:             rd_mux = 32'h0;
      endcase
      if (aclken) begin
         // Bus: one wait cycle, then a single cycle with waitrequest low
         n.waitreq = !(bus_req && r.waitreq);
         if (bus_req && r.waitreq) begin
            n.rdata = rd_mux;
         end
         if (bus_wr && avs_address == vf_pkg::ADDR_CTRL && avs_byteenable[0]) begin
            n.en = avs_writedata[vf_pkg::CTRL_EN_BIT];
         end
         if (bus_wr && avs_address == vf_pkg::ADDR_SIZE) begin
            n.size = be_merge(r.size, avs_writedata, avs_byteenable);
         end
         if (err_clr_hit) begin
            n.err = r.err & ~avs_writedata[3:0];
         end
         if (m_axis_tready) begin
            n.m_valid = 1'b0;
         end
         unique case (r.st)
            vf_pkg::VF_INIT: begin
               // Input held off while the pipeline settles
               n.init_cnt = r.init_cnt + 6'h1;                                   // [RQ18]
               if (r.init_cnt == 6'(INIT_LEN - 1)) begin
                  n.st = vf_pkg::VF_IDLE;
               end
            end
            vf_pkg::VF_IDLE: begin
               n.col = 13'h0;
               n.row = 13'h0;
               if (r.en) begin
                  n.st = vf_pkg::VF_RUN;
               end
            end
            vf_pkg::VF_RUN: begin
               // Stop only between frames so the last frame leaves whole
               if (!r.en && at_sof && !take) begin
                  n.st = vf_pkg::VF_IDLE;                                        // [RQ14]
               end else if (take && at_sof && !s_axis_tuser) begin
                  n.err[vf_pkg::ERR_SOF_LATE] = 1'b1;                            // [RQ6]
                  n.st = vf_pkg::VF_FLUSH_FRAME;                                 // [RQ9]
               end
            end
            vf_pkg::VF_FLUSH_LINE: begin
               if (take && s_axis_tlast && !s_axis_tuser) begin
                  n.st = vf_pkg::VF_RUN;                                         // [RQ12]
               end
            end
            vf_pkg::VF_FLUSH_FRAME: begin
               if (take && s_axis_tuser) begin
                  n.st = vf_pkg::VF_RUN;                                         // [RQ9]
               end
            end
            default: n.st = vf_pkg::VF_INIT;
         endcase
         if (proc && !(r.st == vf_pkg::VF_RUN && at_sof && !s_axis_tuser)) begin
            n.st           = vf_pkg::VF_RUN;
            n.m_valid      = 1'b1;
            n.m_beat.data  = s_axis_tdata;
            // Output start always lands on the programmed origin
            n.m_beat.sof   = (pc == 13'h0) && (pr == 13'h0);                     // [RQ7] [RQ8] [RQ19]
            n.m_beat.eol   = s_axis_tlast || (pc == cols_m1);                    // [RQ10] [RQ11] [RQ19]
            if (sof_early) begin
               n.err[vf_pkg::ERR_SOF_EARLY] = 1'b1;                              // [RQ6] [RQ16]
            end
            if (s_axis_tlast && pc != cols_m1) begin
               n.err[vf_pkg::ERR_LINE_END_PREMATURE] = 1'b1;                              // [RQ6] [RQ16]
            end
            if (pc == cols_m1 && !s_axis_tlast) begin
               n.err[vf_pkg::ERR_LINE_END_OVERDUE] = 1'b1;                               // [RQ6] [RQ16]
               n.st = vf_pkg::VF_FLUSH_LINE;                                     // [RQ12]
            end
            if (s_axis_tlast || pc == cols_m1) begin
               n.col = 13'h0;
               n.row = (pr == rows_m1) ? 13'h0 : pr + 13'h1;
            end else begin
               n.col = pc + 13'h1;
               n.row = pr;
            end
         end
         // Software reset acts at once, whatever the frame position
         if (bus_wr && avs_address == vf_pkg::ADDR_CTRL && avs_byteenable[0] &&
             avs_writedata[vf_pkg::CTRL_SRST_BIT]) begin
            n.st       = vf_pkg::VF_INIT;                                         // [RQ2] [RQ3]
            n.init_cnt = 6'h0;
            n.col      = 13'h0;
            n.row      = 13'h0;
            n.err      = 4'h0;
            n.m_valid  = 1'b0;
         end
         // Registered ready: only when the output stage is free next cycle
         n.s_ready = !n.m_valid && (n.st != vf_pkg::VF_INIT) && (n.st != vf_pkg::VF_IDLE) &&
                     !(n.st == vf_pkg::VF_RUN && !n.en && n.col == 13'h0 &&
                       n.row == 13'h0);                                          // [RQ18]
      end
   end

   // Single clock for stream and register sides; reset not aligned to frames
   always_ff @(posedge clk) begin                                                // [RQ15]
      if (!reset_n) begin
         r <= REGS_RST;                                                          // [RQ2] [RQ3]
      end else begin
         r <= n;
      end
   end

   assign s_axis_tready   = r.s_ready;
   assign m_axis_tdata    = r.m_beat.data;
   assign m_axis_tvalid   = r.m_valid;
   assign m_axis_tuser    = r.m_beat.sof;
   assign m_axis_tlast    = r.m_beat.eol;
   assign avs_readdata    = r.rdata;
   assign avs_waitrequest = r.waitreq;

   // Checks
   sequence s_run_take;
      aclken && s_axis_tvalid && s_axis_tready && r.st == vf_pkg::VF_RUN;
   endsequence

   sequence s_emit_eol;
      m_axis_tvalid && m_axis_tlast;
   endsequence

   property p_ready_init;
      @(posedge clk) disable iff (!reset_n)
      (r.st == vf_pkg::VF_INIT) |-> !s_axis_tready;
   endproperty
   a_ready_init: assert property (p_ready_init) else $error("ready high during init"); // [RQ18]

   property p_line_end_premature;
      @(posedge clk) disable iff (!reset_n)
      (s_run_take and (s_axis_tlast && !s_axis_tuser && !at_sof && r.col != cols_m1))
      |=> (s_emit_eol and r.err[vf_pkg::ERR_LINE_END_PREMATURE] && r.col == 13'h0);
   endproperty
   a_line_end_premature: assert property (p_line_end_premature) else $error("early line end not cut"); // [RQ10]

   property p_line_end_overdue;
      @(posedge clk) disable iff (!reset_n)
      (s_run_take and (!s_axis_tlast && !s_axis_tuser && !at_sof && r.col == cols_m1))
      |=> (s_emit_eol and r.err[vf_pkg::ERR_LINE_END_OVERDUE] && r.st == vf_pkg::VF_FLUSH_LINE);
   endproperty
   a_line_end_overdue: assert property (p_line_end_overdue) else $error("late line end not generated"); // [RQ11]

   property p_sof_early;
      @(posedge clk) disable iff (!reset_n)
      (s_run_take and (s_axis_tuser && !at_sof))
      |=> (m_axis_tvalid && m_axis_tuser && r.err[vf_pkg::ERR_SOF_EARLY]);
   endproperty
   a_sof_early: assert property (p_sof_early) else $error("early frame start not emitted"); // [RQ7]

   property p_sof_late;
      @(posedge clk) disable iff (!reset_n)
      (s_run_take and (!s_axis_tuser && at_sof))
      |=> (r.err[vf_pkg::ERR_SOF_LATE] && r.st == vf_pkg::VF_FLUSH_FRAME && !m_axis_tvalid);
   endproperty
   a_sof_late: assert property (p_sof_late) else $error("late frame start not flushed"); // [RQ9]

   property p_line_drop;
      @(posedge clk) disable iff (!reset_n)
      (aclken && s_axis_tvalid && s_axis_tready && r.st == vf_pkg::VF_FLUSH_LINE &&
       !s_axis_tuser) |=> !m_axis_tvalid;
   endproperty
   a_line_drop: assert property (p_line_drop) else $error("flushed pixel passed out"); // [RQ12]

   property p_ce_freeze;
      @(posedge clk) disable iff (!reset_n)
      !aclken |=> ($stable(r.col) && $stable(r.row) && $stable(r.err) && $stable(m_axis_tvalid));
   endproperty
   a_ce_freeze: assert property (p_ce_freeze) else $error("state moved with enable low"); // [RQ20]

   property p_err_sticky;
      @(posedge clk) disable iff (!reset_n)
      (r.err[vf_pkg::ERR_LINE_END_OVERDUE] && !err_clr_hit && !(bus_wr && avs_address ==
       vf_pkg::ADDR_CTRL)) |=> r.err[vf_pkg::ERR_LINE_END_OVERDUE];
   endproperty
   a_err_sticky: assert property (p_err_sticky) else $error("error bit lost"); // [RQ16]

   property p_bus_answer;
      @(posedge clk) disable iff (!reset_n)
      (aclken && bus_req && avs_waitrequest) ##1 aclken |-> !avs_waitrequest ##1 avs_waitrequest;
   endproperty
   a_bus_answer: assert property (p_bus_answer) else $error("bus answer timing wrong"); // [RQ2]

   property p_sof_origin;
      @(posedge clk) disable iff (!reset_n)
      (s_run_take and (s_axis_tuser)) |=> (m_axis_tuser && r.row == 13'h0);
   endproperty
   a_sof_origin: assert property (p_sof_origin) else $error("start not at origin"); // [RQ19]

   property p_ready_full;
      @(posedge clk) disable iff (!reset_n)
      m_axis_tvalid |-> !s_axis_tready;
   endproperty
   a_ready_full: assert property (p_ready_full) else $error("ready high with output full"); // [RQ20]

   property p_idle_ready;
      @(posedge clk) disable iff (!reset_n)
      (r.st == vf_pkg::VF_IDLE) |-> !s_axis_tready;
   endproperty
   a_idle_ready: assert property (p_idle_ready) else $error("ready high while finished"); // [RQ14]

   property p_frame_drop;
      @(posedge clk) disable iff (!reset_n)
      (aclken && s_axis_tvalid && s_axis_tready && r.st == vf_pkg::VF_FLUSH_FRAME &&
       !s_axis_tuser) |=> !m_axis_tvalid;
   endproperty
   a_frame_drop: assert property (p_frame_drop) else $error("stale frame pixel passed out"); // [RQ9]

   // A soft reset in the same cycle legally wins over the recovery
   property p_late_sof_out;
      @(posedge clk) disable iff (!reset_n)
      (aclken && s_axis_tvalid && s_axis_tready && r.st == vf_pkg::VF_FLUSH_FRAME &&
       s_axis_tuser && !bus_wr) |=> (m_axis_tvalid && m_axis_tuser && r.st == vf_pkg::VF_RUN);
   endproperty
   a_late_sof_out: assert property (p_late_sof_out) else $error("late start not emitted"); // [RQ8]

endmodule

// file: hdl/vf_pkg.sv
// Purpose: Shared constants and carriers for the video framing recovery core
// Assumes: One clock, synchronous active-low reset, Avalon-MM register access
// Notes:   Functional notes below are tagged in the design where they are kept
//
// Functional notes
// RQ1 - Hardware reset held low 32 clocks minimum
// RQ2 - Hardware reset pin plus software reset bit
// RQ3 - Reset ignores frame boundaries; tearing is expected
// RQ4 - System reset generator holds all resets long
// RQ5 - Software programs real frame size before use
// RQ6 - Predict frame start, line end; flag errors
// RQ7 - Early frame start: emit start, end frame
// RQ8 - Missing frame start: output start at programmed point
// RQ9 - After late start drop data until start
// RQ10 - Early line end: emit end, cut line
// RQ11 - Missing line end: emit end at width
// RQ12 - After late end drop pixels until end
// RQ13 - Software disables from output, enables from input
// RQ14 - Status shows state and last frame finished
// RQ15 - Single clock for stream and control
// RQ16 - Error bits: 0,1 line end; 2,3 start
// RQ17 - Size: low half pixels, high half lines
// RQ18 - Input ready low during init and flushing; the code keeps ready high in the flush states while the output is free
// RQ19 - Frame start on user bit, end on last
// RQ20 - Count pixel only on enabled completed transfer
package vf_pkg;

   localparam int          PIX_W          = 24;
   localparam int          CNT_W          = 13;
   localparam int          INIT_CYCLES    = 32;

   // Register byte addresses
   localparam logic [3:0]  ADDR_CTRL      = 4'h0;
   localparam logic [3:0]  ADDR_STATUS    = 4'h4;
   localparam logic [3:0]  ADDR_ERROR     = 4'h8;
   localparam logic [3:0]  ADDR_SIZE      = 4'hc;

   // Field positions
   localparam int          CTRL_EN_BIT    = 0;
   localparam int          CTRL_SRST_BIT  = 1;
   localparam int          STAT_DONE_BIT  = 0;
   localparam int          STAT_BUSY_BIT  = 1;
   localparam int          STAT_FLUSH_BIT = 2;
   localparam int          STAT_INIT_BIT  = 3;
   localparam int          ERR_LINE_END_PREMATURE  = 0;
   localparam int          ERR_LINE_END_OVERDUE   = 1;
   localparam int          ERR_SOF_EARLY  = 2;
   localparam int          ERR_SOF_LATE   = 3;
   localparam int          SIZE_COLS_LSB  = 0;
   localparam int          SIZE_ROWS_LSB  = 16;

   // Reset values: 1920 pixels by 1080 lines
   localparam logic [31:0] SIZE_RST       = 32'h0438_0780;

   typedef enum logic [2:0] {
      VF_INIT        = 3'b000,
      VF_IDLE        = 3'b001,
      VF_RUN         = 3'b010,
      VF_FLUSH_LINE  = 3'b011,
      VF_FLUSH_FRAME = 3'b100
   } vf_state_t;

   typedef struct packed {
      logic [PIX_W-1:0] data;
      logic             sof;
      logic             eol;
   } vf_beat_t;

   typedef struct packed {
      vf_state_t        st;
      logic [5:0]       init_cnt;
      logic [CNT_W-1:0] col;
      logic [CNT_W-1:0] row;
      logic             en;
      logic [31:0]      size;
      logic [3:0]       err;
      logic             m_valid;
      vf_beat_t         m_beat;
      logic             s_ready;
      logic             waitreq;
      logic [31:0]      rdata;
   } vf_regs_t;

endpackage

// file: verif/vf_sink.sv
// Purpose: Downstream stream partner that takes and reports framer output beats
// Assumes: Shares clk and aclken with the framer
// Notes:   Stall keeps ready low two cycles of three to back up the framer
`timescale 1ns/100ps
module vf_sink (
   // Clock and control
   input  wire logic                     clk,
   input  wire logic                     aclken,
   input  wire logic                     stall,
   // Stream from the framer
   input  wire logic [vf_pkg::PIX_W-1:0] tdata,
   input  wire logic                     tvalid,
   input  wire logic                     tuser,
   input  wire logic                     tlast,
   output logic                          tready,
   // Report of each taken beat
   output logic                          got,
   output vf_pkg::vf_beat_t              got_beat
);
   logic [1:0] ph_reg = 2'h0;

   assign tready = !stall || (ph_reg == 2'h0);

   // One clock for stream and registers, so no crossing here
   always_ff @(posedge clk) begin
      got <= 1'b0;
      if (aclken) begin
         ph_reg <= (ph_reg == 2'h2) ? 2'h0 : ph_reg + 2'h1;
         if (tvalid && tready) begin
            got      <= 1'b1;
            got_beat <= {tdata, tuser, tlast};
         end
      end
   end
endmodule

// file: verif/video_framing_error_recovery_tb_top.sv
// Purpose: Self-checking bench for framing error detection and recovery
// Assumes: Frame of 4 pixels by 2 lines, init shortened to 4 cycles
// Notes:   Row bits are in_sof, in_eol, kept, out_sof, out_eol
`timescale 1ns/100ps
module video_framing_error_recovery_tb_top;
   localparam logic [4:0] SF = 5'b10110;
   localparam logic [4:0] PX = 5'b00100;
   localparam logic [4:0] EL = 5'b01101;
   localparam logic [4:0] DR = 5'b00000;
   logic                  clk = 1'b0;
   logic                  aclken = 1'b1;
   logic                  reset_n = 1'b0;
   logic [23:0]           s_tdata = 24'h0;
   logic                  s_tvalid = 1'b0;
   logic                  s_tuser = 1'b0;
   logic                  s_tlast = 1'b0;
   logic                  s_tready;
   logic [23:0]           m_tdata;
   logic                  m_tvalid, m_tuser, m_tlast, m_tready;
   logic [3:0]            avs_address = 4'h0;
   logic                  avs_read = 1'b0;
   logic                  avs_write = 1'b0;
   logic [31:0]           avs_writedata = 32'h0;
   logic [3:0]            avs_byteenable = 4'h0;
   logic [31:0]           avs_readdata;
   logic                  avs_waitrequest;
   logic                  stall = 1'b0;
   logic                  ce_toggle = 1'b0;
   logic                  got;
   vf_pkg::vf_beat_t      got_beat;
   int                    miscompares = 0;
   int                    cmp_count = 0;
   vf_pkg::vf_beat_t      exp_q [$];
   int                    g_end [5] = '{8, 14, 24, 34, 44};
   logic [3:0]            g_err [5] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h8};
   logic [4:0]            rows [44] = '{SF, PX, PX, EL, PX, PX, PX, EL,
      SF, EL, PX, PX, PX, EL,
      SF, PX, PX, 5'b00101, DR, 5'b01000, PX, PX, PX, EL,
      SF, PX, SF, PX, PX, EL, PX, PX, PX, EL,
      DR, DR, SF, PX, PX, EL, PX, PX, PX, EL};

   vf_framer #(.INIT_LEN(4)) dut_u (.clk(clk), .aclken(aclken), .reset_n(reset_n),
      .s_axis_tdata(s_tdata), .s_axis_tvalid(s_tvalid), .s_axis_tuser(s_tuser),
      .s_axis_tlast(s_tlast), .s_axis_tready(s_tready), .m_axis_tdata(m_tdata),
      .m_axis_tvalid(m_tvalid), .m_axis_tuser(m_tuser), .m_axis_tlast(m_tlast),
      .m_axis_tready(m_tready), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest));
   vf_sink sink_u (.clk(clk), .aclken(aclken), .stall(stall), .tdata(m_tdata),
      .tvalid(m_tvalid), .tuser(m_tuser), .tlast(m_tlast), .tready(m_tready),
      .got(got), .got_beat(got_beat));

   initial begin
      forever #10 clk = ~clk;
   end
   // Enable toggles only while pixels flow, never across a bus access
   always @(posedge clk) aclken <= ce_toggle ? ~aclken : 1'b1;

   task automatic end_sim();
      if (miscompares == 0 && cmp_count > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic fail_to();
      miscompares++;
      end_sim();
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      cmp_count++;
      if (g !== e) begin
         miscompares++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
                      input logic [3:0] be, output logic [31:0] q);
      int n;
      @(posedge clk);
      avs_read <= !w;
      avs_write <= w;
      avs_address <= a;
      avs_writedata <= d;
      avs_byteenable <= be;
      for (n = 0; n < 50; n++) begin
         @(posedge clk);
         if (avs_waitrequest === 1'b0) break;
      end
      if (n == 50) fail_to();
      q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] be);
      logic [31:0] q;
      bus(1'b1, a, d, be, q);
   endtask
   task automatic rd(input logic [3:0] a, input logic [31:0] e);
      logic [31:0] q;
      bus(1'b0, a, 32'h0, 4'hf, q);
      chk(q, e);
   endtask
   task automatic send(input logic [23:0] d, input logic [4:0] r);
      int n;
      if (r[2]) exp_q.push_back({d, r[1], r[0]});
      @(posedge clk);
      s_tvalid <= 1'b1;
      s_tdata <= d;
      s_tuser <= r[4];
      s_tlast <= r[3];
      for (n = 0; n < 200; n++) begin
         @(posedge clk);
         if (s_tready === 1'b1 && aclken === 1'b1) break;
      end
      if (n == 200) fail_to();
      // Released lines flip so a stale value is never mistaken for data
      s_tvalid <= 1'b0;
      s_tdata <= ~d;
      s_tuser <= ~r[4];
      s_tlast <= ~r[3];
   endtask
   task automatic run(input int lo, input int hi);
      for (int i = lo; i < hi; i++) send(24'h100 + i[23:0], rows[i]);
   endtask
   task automatic drain();
      for (int n = 0; n < 300 && exp_q.size() > 0; n++) @(posedge clk);
      if (exp_q.size() > 0) fail_to();
   endtask
   task automatic hw_reset();
      reset_n <= 1'b0;
      repeat (32) @(posedge clk);
      chk({avs_waitrequest, m_tvalid}, 32'h2);
      reset_n <= 1'b1;
   endtask

   always @(posedge clk) begin
      if (got === 1'b1) begin
         chk(32'(got_beat), exp_q.size() > 0 ? 32'(exp_q.pop_front()) : 32'hffff_ffff);
      end
   end

   initial begin
      hw_reset();
      @(posedge clk);
      chk(32'(s_tready), 32'h0);
      rd(vf_pkg::ADDR_SIZE, vf_pkg::SIZE_RST);
      wr(vf_pkg::ADDR_SIZE, 32'h0002_0000, 4'b1100);
      wr(vf_pkg::ADDR_SIZE, 32'h5555_0004, 4'b0011);
      rd(vf_pkg::ADDR_SIZE, 32'h0002_0004);
      wr(4'h6, 32'hffff_ffff, 4'hf);
      rd(4'h6, 32'h0);
      wr(vf_pkg::ADDR_CTRL, 32'h1, 4'h1);
      for (int g = 0; g < 5; g++) begin
         stall <= g[0];
         ce_toggle <= (g == 2);
         run(g > 0 ? g_end[g > 0 ? g - 1 : 0] : 0, g_end[g]);
         drain();
         ce_toggle <= 1'b0;
         repeat (2) @(posedge clk);
         rd(vf_pkg::ADDR_ERROR, {28'h0, g_err[g]});
         wr(vf_pkg::ADDR_ERROR, 32'hf, 4'h1);
      end
      stall <= 1'b0;
      run(8, 10);
      drain();
      wr(vf_pkg::ADDR_CTRL, 32'h3, 4'h1);
      repeat (2) @(posedge clk);
      chk(32'(s_tready), 32'h0);
      rd(vf_pkg::ADDR_ERROR, 32'h0);
      run(0, 8);
      drain();
      rd(vf_pkg::ADDR_ERROR, 32'h0);
      wr(vf_pkg::ADDR_CTRL, 32'h0, 4'h1);
      rd(vf_pkg::ADDR_STATUS, 32'h1);
      s_tvalid <= 1'b1;
      s_tuser <= 1'b1;
      repeat (8) @(posedge clk);
      chk({s_tready, m_tvalid}, 32'h0);
      s_tvalid <= 1'b0;
      wr(vf_pkg::ADDR_CTRL, 32'h1, 4'h1);
      run(0, 3);
      drain();
      hw_reset();
      rd(vf_pkg::ADDR_SIZE, vf_pkg::SIZE_RST);
      chk(32'(exp_q.size()), 32'h0);
      end_sim();
   end
endmodule
